// file: src_pkg.sv
// Package: register map, field layout and modes of the SYSREF capture control
package src_pkg;

  // ---------------------------------------------------------------
  // Register addresses on the control port
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 15;
  localparam logic [14:0] ADDR_MODE_CTRL  = 15'h0120; // Mode control
  localparam logic [14:0] ADDR_NSHOT_CTRL = 15'h0121; // N-shot ignore
  localparam logic [14:0] ADDR_SKEW_CTRL  = 15'h0122; // Skew windows
  localparam logic [14:0] ADDR_EVT_COUNT  = 15'h012a; // Event counter

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned BIT_FLAG_RST  = 6; // Counter held in reset
  localparam int unsigned BIT_FALL_TRAN = 4; // Transition polarity
  localparam int unsigned BIT_FALL_EDGE = 3; // Converter clock edge
  localparam int unsigned MODE_HI       = 2; // Mode field top
  localparam int unsigned MODE_LO       = 1; // Mode field bottom
  localparam int unsigned IGN_HI        = 3; // Ignore count top
  localparam int unsigned NEG_HI        = 3; // Negative window top
  localparam int unsigned NEG_LO        = 2; // Negative window bottom
  localparam int unsigned POS_HI        = 1; // Positive window top

  // Register reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // Writable bit masks; reserved bits always read back as zero
  localparam logic [7:0] MASK_MODE   = 8'h5e; // Flag, polarity, edge, mode
  localparam logic [7:0] MASK_NIBBLE = 8'h0f; // Low nibble registers

  // Lookahead depth equals the widest skew window in sample clocks
  localparam int unsigned LOOK = 3;

  // Capture modes
  typedef enum logic [1:0] {
    SRC_MODE_OFF  = 2'b00,
    SRC_MODE_CONT = 2'b01,
    SRC_MODE_NSHOT = 2'b10
  } src_mode_e;

  // Decoded configuration carried to the capture logic
  typedef struct packed {
    logic       fallTran; // Accept high-to-low transitions
    logic       fallEdge; // Sample on falling converter clock edge
    logic [1:0] mode;     // Capture mode field
    logic [3:0] ignore;   // Transitions skipped in N-shot mode
    logic [1:0] negWin;   // Negative skew window
    logic [1:0] posWin;   // Positive skew window
  } src_cfg_s;

endpackage

// file: src_edge_sampler.sv
// Sampler: synchronises the pins and finds valid reference transitions
`timescale 1ns/1ps
module src_edge_sampler
  import src_pkg::*;
(
  input  wire logic core_clk,   // System clock
  input  wire logic reset,      // Synchronous reset, active high
  input  wire logic sysrefPin,  // Timing reference pin
  input  wire logic convClkPin, // Converter clock pin
  input  wire logic fallEdge,   // Sample on falling converter edge
  input  wire logic fallTran,   // Accept high-to-low transitions
  output logic      sampleStep, // One pulse per chosen converter edge
  output logic      validEvt    // Valid transition seen this step
);

  // ---------------------------------------------------------------
  // Synchronisers and history
  // ---------------------------------------------------------------
  logic [1:0] refSync_q, refSync_d; // Reference two-flop chain
  logic [1:0] clkSync_q, clkSync_d; // Converter clock two-flop chain
  logic       clkPrev_q, clkPrev_d; // Last synchronised clock level
  logic       refNow_q,  refNow_d;  // Reference at the latest step

  // Next values: edge of the chosen polarity opens a sample step
  always_comb begin
    refSync_d  = {refSync_q[0], sysrefPin};
    clkSync_d  = {clkSync_q[0], convClkPin};
    clkPrev_d  = clkSync_q[1];
    // Rising edge when select low, falling when high
    sampleStep = fallEdge ? (clkPrev_q & ~clkSync_q[1])
                          : (~clkPrev_q & clkSync_q[1]);
    refNow_d   = refNow_q;
    if (sampleStep) begin
      refNow_d  = refSync_q[1];
    end
  end

  // Registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      refSync_q <= 2'b00;
      clkSync_q <= 2'b00;
      clkPrev_q <= 1'b0;
      refNow_q  <= 1'b0;
    end else begin
      refSync_q <= refSync_d;
      clkSync_q <= clkSync_d;
      clkPrev_q <= clkPrev_d;
      refNow_q  <= refNow_d;
    end
  end

  // Polarity of a valid transition follows the select bit
  always_comb begin
    validEvt = sampleStep &
               (fallTran ? (refNow_q & ~refSync_q[1])
                         : (~refNow_q & refSync_q[1]));
  end

endmodule

// file: src_capture_ctrl.sv
// Capture control: registers, skew windows, modes and event counter
`timescale 1ns/1ps
module src_capture_ctrl
  import src_pkg::*;
(
  input  wire logic              core_clk,   // System clock, 50 MHz
  input  wire logic              reset,      // Synchronous reset
  input  wire logic              sysrefPin,  // Timing reference pin
  input  wire logic              convClkPin, // Converter clock pin
  input  wire logic              alignTick,  // Intended sample clock
  input  wire logic [ADDR_W-1:0] regAddr,    // Register address
  input  wire logic              regWr,      // Write strobe
  input  wire logic [7:0]        regWrData,  // Write data
  input  wire logic              regRd,      // Read strobe
  output logic [7:0]             regRdData,  // Read data, next cycle
  output logic                   captureEvt, // Accepted capture pulse
  output logic                   captureOn   // Capture still armed
);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] modeReg_q,  modeReg_d;  // Mode control register
  logic [7:0] nshotReg_q, nshotReg_d; // N-shot ignore register
  logic [7:0] skewReg_q,  skewReg_d;  // Skew window register
  logic [7:0] rdData_q,   rdData_d;   // Read data holding flop
  logic       modeWr;                 // Mode register written
  logic [7:0] evtCnt_q,   evtCnt_d;   // Captured event counter
  src_cfg_s   cfg;                    // Decoded configuration

  // Decode writes; reserved bits are kept at zero
  always_comb begin
    modeReg_d  = modeReg_q;
    nshotReg_d = nshotReg_q;
    skewReg_d  = skewReg_q;
    modeWr     = 1'b0;
    if (regWr) begin
      unique case (regAddr)
        ADDR_MODE_CTRL: begin
          modeReg_d = regWrData & MASK_MODE;
          modeWr    = 1'b1;
        end
        ADDR_NSHOT_CTRL: begin
          nshotReg_d = regWrData & MASK_NIBBLE;
        end
        ADDR_SKEW_CTRL: begin
          skewReg_d = regWrData & MASK_NIBBLE;
        end
        default: begin
          // Unmapped or read-only: write ignored
          modeWr = 1'b0;
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rdData_d = rdData_q;
    if (regRd) begin
      unique case (regAddr)
        ADDR_MODE_CTRL:  rdData_d = modeReg_q;
        ADDR_NSHOT_CTRL: rdData_d = nshotReg_q;
        ADDR_SKEW_CTRL:  rdData_d = skewReg_q;
        ADDR_EVT_COUNT:  rdData_d = evtCnt_q;
        default:         rdData_d = 8'h00;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge core_clk) begin
    if (reset) begin
      modeReg_q  <= RST_REG;
      nshotReg_q <= RST_REG;
      skewReg_q  <= RST_REG;
      rdData_q   <= RST_REG;
    end else begin
      modeReg_q  <= modeReg_d;
      nshotReg_q <= nshotReg_d;
      skewReg_q  <= skewReg_d;
      rdData_q   <= rdData_d;
    end
  end

  assign regRdData = rdData_q;

  // Field decode into the configuration carrier
  always_comb begin
    cfg.fallTran = modeReg_q[BIT_FALL_TRAN];
    cfg.fallEdge = modeReg_q[BIT_FALL_EDGE];
    cfg.mode     = modeReg_q[MODE_HI:MODE_LO];
    cfg.ignore   = nshotReg_q[IGN_HI:0];
    cfg.negWin   = skewReg_q[NEG_HI:NEG_LO];
    cfg.posWin   = skewReg_q[POS_HI:0];
  end

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  logic sampleStep; // Chosen converter edge seen
  logic validEvt;   // Valid transition on this step
  logic tickSync1_q, tickSync2_q; // Tick synchroniser

  // Polarity changes are only safe with capture disabled
  src_edge_sampler uSampler (
    .core_clk   (core_clk),
    .reset      (reset),
    .sysrefPin  (sysrefPin),
    .convClkPin (convClkPin),
    .fallEdge   (cfg.fallEdge),
    .fallTran   (cfg.fallTran),
    .sampleStep (sampleStep),
    .validEvt   (validEvt)
  );

  // Tick comes from the pin side, so two flops first
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tickSync1_q <= 1'b0;
      tickSync2_q <= 1'b0;
    end else begin
      tickSync1_q <= alignTick;
      tickSync2_q <= tickSync1_q;
    end
  end

  // ---------------------------------------------------------------
  // Skew windows
  // ---------------------------------------------------------------
  logic [LOOK:0] evtHist_q,  evtHist_d;  // Events per sample step
  logic [LOOK:0] tickHist_q, tickHist_d; // Ticks per sample step
  logic [2:0]    since_q,    since_d;    // Steps since delayed tick
  logic          negHit;                 // Tick follows within window
  logic          posHit;                 // Tick precedes within window
  logic          winEvt;                 // Event surviving windows

  // Events are delayed by the widest window so later ticks are known
  always_comb begin
    evtHist_d  = evtHist_q;
    tickHist_d = tickHist_q;
    since_d    = since_q;
    negHit     = 1'b0;
    posHit     = 1'b0;
    // Tick up to negWin steps after the event: discard
    for (int j = 1; j <= LOOK; j++) begin
      if (j <= int'(cfg.negWin) && tickHist_q[LOOK-j]) begin
        negHit = 1'b1;
      end
    end
    // Tick 1..posWin steps before the event: ignore
    if (!tickHist_q[LOOK] && since_q != 3'd0 &&
        since_q <= {1'b0, cfg.posWin}) begin
      posHit = 1'b1;
    end
    // Window zero leaves both hits clear: no tolerance given
    winEvt = sampleStep & evtHist_q[LOOK] & ~negHit & ~posHit;
    if (sampleStep) begin
      evtHist_d  = {evtHist_q[LOOK-1:0], validEvt};
      tickHist_d = {tickHist_q[LOOK-1:0], tickSync2_q};
      // Age of the last tick seen by the delayed stream, saturating
      if (tickHist_q[LOOK]) begin
        since_d = 3'd1;
      // Saturate past the widest window so an old tick never matches
      end else if (since_q != 3'd0 && since_q != 3'(LOOK + 1)) begin
        since_d = since_q + 3'd1;
      end
    end
  end

  // Window history registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      evtHist_q  <= '0;
      tickHist_q <= '0;
      since_q    <= 3'd0;
    end else begin
      evtHist_q  <= evtHist_d;
      tickHist_q <= tickHist_d;
      since_q    <= since_d;
    end
  end

  // ---------------------------------------------------------------
  // Capture modes
  // ---------------------------------------------------------------
  logic [3:0] skipLeft_q, skipLeft_d; // Transitions still to skip
  logic       done_q,     done_d;     // N-shot has fired
  logic       capEvt_q,   capEvt_d;   // Registered capture pulse

  // Mode sequencing; any mode write rearms N-shot
  always_comb begin
    skipLeft_d = skipLeft_q;
    done_d     = done_q;
    capEvt_d   = 1'b0;
    evtCnt_d   = evtCnt_q;
    if (modeWr) begin
      skipLeft_d = cfg.ignore;
      done_d     = 1'b0;
      if (regAddr == ADDR_MODE_CTRL) begin
        skipLeft_d = nshotReg_q[IGN_HI:0];
      end
    end else if (winEvt) begin
      unique case (cfg.mode)
        SRC_MODE_CONT: begin
          capEvt_d = 1'b1;
        end
        SRC_MODE_NSHOT: begin
          if (!done_q) begin
            if (skipLeft_q != 4'd0) begin
              skipLeft_d = skipLeft_q - 4'd1;
            end else begin
              capEvt_d = 1'b1;
              done_d   = 1'b1;
            end
          end
        end
        default: begin
          // Disabled or reserved code: nothing captured
          capEvt_d = 1'b0;
        end
      endcase
    end
    // Counter wraps naturally at its width; flag reset holds it
    if (modeReg_q[BIT_FLAG_RST]) begin
      evtCnt_d = 8'h00;
    end else if (capEvt_d) begin
      evtCnt_d = evtCnt_q + 8'h01;
    end
  end

  // Mode state registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      skipLeft_q <= 4'd0;
      done_q     <= 1'b0;
      capEvt_q   <= 1'b0;
      evtCnt_q   <= 8'h00;
    end else begin
      skipLeft_q <= skipLeft_d;
      done_q     <= done_d;
      capEvt_q   <= capEvt_d;
      evtCnt_q   <= evtCnt_d;
    end
  end

  // Outputs
  assign captureEvt = capEvt_q;
  assign captureOn  = (cfg.mode == SRC_MODE_CONT) |
                      ((cfg.mode == SRC_MODE_NSHOT) & ~done_q);

endmodule

// file: src_capture_properties.sv
// Checker: port-level properties of the capture control
`timescale 1ns/1ps
module src_capture_properties
  import src_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic              regWr,
  input wire logic [7:0]        regWrData,
  input wire logic              regRd,
  input wire logic [7:0]        regRdData,
  input wire logic              captureEvt,
  input wire logic              captureOn
);
  logic [7:0] ctlQ, ctlD, ignQ, ignD, skwQ, skwD, cntQ, cntD, rdExp;
  logic       firedQ, firedD, wrCtl, nsh, offNow;
  assign wrCtl  = regWr && regAddr == ADDR_MODE_CTRL;
  assign nsh    = ctlQ[2:1] == SRC_MODE_NSHOT;
  assign offNow = ctlQ[2:1] == SRC_MODE_OFF || ctlQ[2:1] == 2'b11;
  // Shadow copy of the registers, the fired flag and the event count
  always_comb begin
    ctlD   = wrCtl ? regWrData & 8'h5e : ctlQ;
    ignD   = (regWr && regAddr == ADDR_NSHOT_CTRL) ? regWrData & 8'h0f : ignQ;
    skwD   = (regWr && regAddr == ADDR_SKEW_CTRL) ? regWrData & 8'h0f : skwQ;
    firedD = !wrCtl && (firedQ || captureEvt);
    cntD   = ctlQ[BIT_FLAG_RST] ? 8'h00 : cntQ + {7'h00, captureEvt};
    case (regAddr)
      ADDR_MODE_CTRL:  rdExp = ctlQ;
      ADDR_NSHOT_CTRL: rdExp = ignQ;
      ADDR_SKEW_CTRL:  rdExp = skwQ;
      default:         rdExp = 8'h00;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      {ctlQ, ignQ, skwQ, cntQ, firedQ} <= '0;
    end else begin
      {ctlQ, ignQ, skwQ, cntQ, firedQ} <= {ctlD, ignD, skwD, cntD, firedD};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_reset_quiet: assert property ($fell(reset) |->
    !captureEvt && !captureOn && regRdData == 8'h00) else $error("not idle");
  a_evt_pulse: assert property (captureEvt |=> !captureEvt)
    else $error("capture pulse too long");
  a_off_silent: assert property (offNow && $past(offNow) |->
    !captureEvt) else $error("capture while disabled");
  a_cont_armed: assert property (!nsh |->
    captureOn == (ctlQ[2:1] == SRC_MODE_CONT)) else $error("armed level wrong");
  a_nshot_single: assert property (nsh && firedQ |-> !captureEvt)
    else $error("second one-shot capture");
  a_nshot_armed: assert property (nsh && !firedQ && !captureEvt |->
    captureOn) else $error("one-shot disarmed early");
  a_count_read: assert property (regRd && regAddr == ADDR_EVT_COUNT
    && !captureOn && !captureEvt |=> regRdData == $past(cntQ))
    else $error("count wrong");
  a_read_back: assert property (regRd && regAddr != ADDR_EVT_COUNT
    |=> regRdData == $past(rdExp)) else $error("read data wrong");
  a_read_hold: assert property (!regRd |=> $stable(regRdData))
    else $error("read data moved");
  cover property (captureEvt && nsh);
  cover property (captureEvt && ctlQ[2:1] == SRC_MODE_CONT);
  cover property (regRd && regAddr == ADDR_EVT_COUNT);
endmodule

// file: src_ref_source.sv
// Partner: free converter clock, reference level and alignment marker
`timescale 1ns/1ps
module src_ref_source #(
  parameter int HALF = 160 // Half period of the converter clock in ns
)(
  output logic sysrefPin,
  output logic convClkPin,
  output logic alignTick
);
  initial begin
    sysrefPin  = 1'b0;
    convClkPin = 1'b0;
    alignTick  = 1'b0;
  end
  // Converter clock runs free
  always #(HALF) convClkPin = ~convClkPin;
  // One transition to lvl at step 2; marker across step 2+off
  task automatic xfer(input logic lvl, input int off);
    for (int i = 0; i < 6; i++) begin
      @(posedge convClkPin);
      #5;
      if (i == 0) sysrefPin = ~lvl;
      if (i == 1) sysrefPin = lvl;
      alignTick = (i == 1 + off);
    end
    @(posedge convClkPin);
    #5 alignTick = 1'b0;
  endtask
endmodule

// file: sysref_capture_control_tb.sv
// Testbench: register access, polarity, modes, one-shot and skew windows
`timescale 1ns/1ps
module sysref_capture_control_tb;
  import src_pkg::*;
  logic              core_clk, reset, regWr, regRd;
  logic [ADDR_W-1:0] regAddr;
  logic [7:0]        regWrData, regRdData;
  logic              captureEvt, captureOn, sysrefPin, convClkPin, alignTick;
  int                errors, samples_checked, evtCount, n;
  int                ign [3] = '{0, 1, 15};
  int                win [9][3] = '{'{0, 1, 1}, '{4, 1, 0}, '{4, 0, 1},
                                    '{1, -1, 0}, '{1, 0, 1}, '{0, -1, 1},
                                    '{12, 3, 0}, '{3, 99, 1}, '{3, -1, 0}};
  src_capture_ctrl u_dut (.core_clk(core_clk), .reset(reset),
    .sysrefPin(sysrefPin), .convClkPin(convClkPin), .alignTick(alignTick),
    .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData), .regRd(regRd),
    .regRdData(regRdData), .captureEvt(captureEvt), .captureOn(captureOn));
  src_ref_source u_src (.sysrefPin(sysrefPin), .convClkPin(convClkPin),
    .alignTick(alignTick));
  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;
  // Count capture pulses
  always @(posedge core_clk) if (captureEvt === 1'b1) evtCount++;
  task automatic check(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #2 {regAddr, regWrData, regWr} = {a, d, 1'b1};
    @(posedge core_clk);
    #2 regWr = 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge core_clk);
    #2 {regAddr, regRd} = {a, 1'b1};
    @(posedge core_clk);
    #2 regRd = 1'b0;
    @(posedge core_clk);
    #2 check("read data", regRdData, e);
  endtask
  // One reference transition to lvl, then count the captures it caused
  task automatic pulse(input logic lvl, input int off, input int e);
    int base;
    base = evtCount;
    u_src.xfer(lvl, off);
    repeat (8) @(posedge convClkPin);
    #2 check("capture count", 8'(evtCount - base), 8'(e));
  endtask
  task automatic summarize();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #1_000_000;
    errors++;
    summarize();
  end
  initial begin
    reset = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWrData = 8'h00;
    repeat (8) @(posedge core_clk);
    #2 reset = 1'b0;
    rd(ADDR_MODE_CTRL, 8'h00);
    rd(ADDR_NSHOT_CTRL, 8'h00);
    rd(ADDR_SKEW_CTRL, 8'h00);
    rd(15'h0125, 8'h00);
    wr(ADDR_MODE_CTRL, 8'hff);
    rd(ADDR_MODE_CTRL, 8'h5e);
    wr(ADDR_NSHOT_CTRL, 8'hff);
    rd(ADDR_NSHOT_CTRL, 8'h0f);
    wr(ADDR_SKEW_CTRL, 8'hff);
    rd(ADDR_SKEW_CTRL, 8'h0f);
    wr(ADDR_EVT_COUNT, 8'hff);
    rd(ADDR_EVT_COUNT, 8'h00);
    wr(ADDR_SKEW_CTRL, 8'h00);
    wr(ADDR_NSHOT_CTRL, 8'h00);
    // Every polarity and converter edge, capture disabled around changes
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_MODE_CTRL, 8'h00);
      wr(ADDR_MODE_CTRL, {3'h0, 2'(c), 3'h2});
      pulse(!c[1], 99, 1);
      pulse(c[1], 99, 0);
    end
    wr(ADDR_MODE_CTRL, 8'h00);
    rd(ADDR_EVT_COUNT, 8'h04);
    wr(ADDR_MODE_CTRL, 8'h40);
    wr(ADDR_MODE_CTRL, 8'h00);
    rd(ADDR_EVT_COUNT, 8'h00);
    pulse(1'b1, 99, 0);
    wr(ADDR_MODE_CTRL, 8'h06);
    pulse(1'b1, 99, 0);
    // One-shot with several ignore counts
    foreach (ign[k]) begin
      wr(ADDR_NSHOT_CTRL, 8'(ign[k]));
      wr(ADDR_MODE_CTRL, 8'h04);
      #2 check("armed", {7'h00, captureOn}, 8'h01);
      for (n = 0; n < ign[k]; n++) pulse(1'b1, 99, 0);
      pulse(1'b1, 99, 1);
      check("armed", {7'h00, captureOn}, 8'h00);
      pulse(1'b1, 99, 0);
    end
    // Skew windows against the alignment marker
    wr(ADDR_MODE_CTRL, 8'h02);
    foreach (win[k]) begin
      wr(ADDR_SKEW_CTRL, 8'(win[k][0]));
      pulse(1'b1, win[k][1], win[k][2]);
    end
    summarize();
  end
endmodule
bind src_capture_ctrl src_capture_properties u_props (.core_clk(core_clk),
  .reset(reset), .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData),
  .regRd(regRd), .regRdData(regRdData), .captureEvt(captureEvt),
  .captureOn(captureOn));
